// [csc_pkg.sv]
// Purpose: constants, field layouts and carrier types of the clock source control block
// Assumes: 16-bit register data, word-indexed register port, 100 MHz system clock
// Notes:   clock sources arrive as sampled levels and are switched on i_clk edges
package csc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned INT_OSC_MHZ     = 10;
  localparam int unsigned INT_OSC_PERIOD_NS = 1000 / INT_OSC_MHZ;
  localparam int unsigned INT_OSC_HALF_CYC  = INT_OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned MCLK_TIMEOUT_NS = 1000;
  localparam int unsigned MCLK_CYCLES     = (MCLK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MCLK_CNT_W      = 8;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] IDX_EXT_CLOCK   = 4'h0;
  localparam logic [3:0] IDX_PLL_STATUS  = 4'h1;
  localparam logic [3:0] IDX_CLOCK_CTRL  = 4'h2;
  localparam logic [3:0] IDX_LOCK_PERIOD = 4'h3;
  localparam logic [3:0] IDX_OSC1_TRIM   = 4'h4;
  localparam logic [3:0] IDX_OSC2_TRIM   = 4'h5;
  localparam logic [3:0] IDX_PLL_MULT    = 4'h6;
  localparam logic [3:0] IDX_GATE_A      = 4'h7;
  localparam logic [3:0] IDX_GATE_D      = 4'h8;
  localparam logic [3:0] IDX_DEBUG_PORT  = 4'h9;

  // ext_clock_register
  localparam int unsigned EXT_PIN_SEL_BIT = 6;
  // pll_status_reg
  localparam int unsigned PLL_LOCK_BIT    = 0;
  localparam int unsigned MISS_FLAG_BIT   = 3;
  localparam int unsigned DIV_LSB         = 7;
  localparam int unsigned REG_READY_BIT   = 15;
  localparam logic [1:0]  DIV_BY_4        = 2'h0;
  localparam logic [1:0]  DIV_BY_2        = 2'h2;
  localparam logic [1:0]  DIV_BY_1        = 2'h3;
  localparam logic [1:0]  DIV_RESET       = DIV_BY_4;
  // pll_multiplier_reg
  localparam logic [3:0]  PLL_MULT_MAX    = 4'hc;
  localparam logic [3:0]  PLL_MULT_RESET  = 4'h0;
  // pll_lock_period_reg
  localparam logic [15:0] LOCK_PERIOD_RESET = 16'hffff;
  // trim registers
  localparam logic [15:0] TRIM_RESET      = 16'h0000;
  // periph_clock_gate_reg_a
  localparam int unsigned GATE_HIGH_RES_PWM_BIT  = 0;
  localparam int unsigned GATE_LIN_BIT    = 1;
  localparam logic [15:0] GATE_A_MASK     = 16'h0003;
  localparam logic [15:0] GATE_A_RESET    = 16'h0000;
  // periph_clock_gate_reg_d: comparators 2:0, timers 10:8, gpio input 13, accelerator 14
  localparam int unsigned GATE_TMR2_BIT   = 10;
  localparam int unsigned GATE_GPIO_BIT   = 13;
  localparam logic [15:0] GATE_D_MASK     = 16'h6707;
  localparam logic [15:0] GATE_D_RESET    = 16'h2700;
  // debug_port_enable_reg
  localparam logic [15:0] DEBUG_RESET     = 16'h0001;

  // source selector codes
  localparam logic [1:0] SRC_INT1 = 2'h0;
  localparam logic [1:0] SRC_INT2 = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_EXT  = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext;
    logic xtal;
    logic int2;
    logic int1;
  } csc_src_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       mclk_rst_wd;
    logic       ext_off;
    logic       xtal_off;
    logic       wd_halt_ign;
    logic       int2_halt_ign;
    logic       int2_off;
    logic       int1_halt_ign;
    logic       int1_off;
    logic [1:0] tmr2_src;
    logic [1:0] wd_src;
    logic [1:0] osc_src;
  } csc_clk_ctl_t;

  localparam logic [15:0] CLK_CTL_MASK  = 16'h3fff;
  localparam logic [15:0] CLK_CTL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PLL_IDLE,
    PLL_WAIT,
    PLL_LOCKED
  } csc_pll_state_t;

  function automatic logic csc_pick(input csc_src_t src, input logic [1:0] sel);
    logic [3:0] v;
    v = src;
    return v[sel];
  endfunction

endpackage

// [csc_clk_switch.sv]
// Purpose: glitch-free selection of one of four sampled clock levels
// Assumes: source levels are synchronous to i_clk
// Notes:   the selection moves only while both the output and the new source are low
`timescale 1ns/1ps
`default_nettype none
module csc_clk_switch
  import csc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire csc_src_t   i_src,
  input  wire logic [1:0] i_sel,
  input  wire logic       i_en,
  output logic            o_clk,
  output logic [1:0]      o_sel
);

  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic       clk_q;
  logic       clk_d;

  always_comb begin
    sel_d = sel_q;
    if (!clk_q && !csc_pick(i_src, i_sel)) begin
      sel_d = i_sel;
    end
    clk_d = i_en & csc_pick(i_src, sel_d);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q <= SRC_INT1;
      clk_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      clk_q <= clk_d;
    end
  end

  assign o_clk = clk_q;
  assign o_sel = sel_q;

endmodule
`default_nettype wire

// [csc_clock_source_control.sv]
// Purpose: clock source selection, post-divider, pll lock, missing clock and gating control
// Assumes: all source levels and strobes synchronous to i_clk; read data one cycle after strobe
// Notes:   oscillator levels are sampled, so a source must be well below half the clock rate
`timescale 1ns/1ps
`default_nettype none
module csc_clock_source_control
  import csc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_int1_osc,
  input  wire logic              i_int2_osc,
  input  wire logic              i_xtal_osc,
  input  wire logic              i_ext_pin_a,
  input  wire logic              i_ext_pin_b,
  input  wire logic              i_halt,
  input  wire logic              i_reg_ready,
  input  wire logic              i_nmi_wd_expired,
  output logic                   o_oscillator_clock,
  output logic                   o_cpu_clock,
  output logic                   o_watchdog_clock,
  output logic                   o_timer2_clock,
  output logic                   o_ext_clk_pin_select,
  output logic                   o_int1_enable,
  output logic                   o_int2_enable,
  output logic                   o_xtal_enable,
  output logic                   o_ext_enable,
  output logic      [15:0]       o_osc1_trim,
  output logic      [15:0]       o_osc2_trim,
  output logic      [3:0]        o_pll_mult,
  output logic                   o_pll_enable,
  output logic                   o_missing_clock_reset_n,
  output logic      [15:0]       o_periph_gate_a,
  output logic      [15:0]       o_periph_gate_d,
  output logic                   o_gpio_input_reset,
  output logic                   o_debug_port_enable
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic           ext_sel_q,  ext_sel_d;
  logic [1:0]     div_sel_q,  div_sel_d;
  logic           miss_q,     miss_d;
  logic           rdy_gate_q, rdy_gate_d;
  csc_clk_ctl_t   ctl_q,      ctl_d;
  logic [15:0]    lock_prd_q, lock_prd_d;
  logic [15:0]    trim1_q,    trim1_d;
  logic [15:0]    trim2_q,    trim2_d;
  logic [3:0]     mult_q,     mult_d;
  logic [15:0]    gate_a_q,   gate_a_d;
  logic [15:0]    gate_d_q,   gate_d_d;
  logic [15:0]    dbg_q,      dbg_d;
  logic [15:0]    rdata_q,    rdata_d;

  csc_pll_state_t pll_st_q,   pll_st_d;
  logic [15:0]    lock_cnt_q, lock_cnt_d;
  logic           pll_en_q,   pll_en_d;

  logic [MCLK_CNT_W-1:0] mc_cnt_q, mc_cnt_d;
  logic           mc_prev_q,  mc_prev_d;
  logic           mrst_n_q,   mrst_n_d;
  logic           fail;

  logic [1:0]     div_cur_q,  div_cur_d;
  logic [1:0]     div_cnt_q,  div_cnt_d;
  logic           cpu_q,      cpu_d;
  logic           osc_prev_q, osc_prev_d;

  logic           wr_ctl;
  logic [15:0]    status_view;
  csc_src_t       src;
  logic           osc_clk;
  logic           wd_clk;
  logic           t2_clk;
  logic [1:0]     osc_sel_cur;
  logic           wd_en;

  // ----------------------------------------------------------------
  // source sampling and gating
  // ----------------------------------------------------------------
  always_comb begin
    src.int1 = i_int1_osc;
    src.int2 = i_int2_osc;
    src.xtal = i_xtal_osc;
    src.ext  = ext_sel_q ? i_ext_pin_b : i_ext_pin_a;
  end

  assign wd_en = !(i_halt && !ctl_q.wd_halt_ign);

  csc_clk_switch u_osc_sw (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_src  (src),
    .i_sel  (ctl_q.osc_src),
    .i_en   (1'b1),
    .o_clk  (osc_clk),
    .o_sel  (osc_sel_cur)
  );

  csc_clk_switch u_wd_sw (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_src  (src),
    .i_sel  (ctl_q.wd_src),
    .i_en   (wd_en),
    .o_clk  (wd_clk),
    .o_sel  ()
  );

  csc_clk_switch u_t2_sw (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_src  (src),
    .i_sel  (ctl_q.tmr2_src),
    .i_en   (gate_d_q[GATE_TMR2_BIT]),
    .o_clk  (t2_clk),
    .o_sel  ()
  );

  // ----------------------------------------------------------------
  // missing clock detection
  // ----------------------------------------------------------------
  always_comb begin
    mc_prev_d = csc_pick(src, osc_sel_cur);
    mc_cnt_d  = mc_cnt_q;
    fail      = 1'b0;
    if (mc_prev_d != mc_prev_q) begin
      mc_cnt_d = '0;
    end else if (mc_cnt_q == MCLK_CNT_W'(MCLK_CYCLES - 1)) begin
      fail     = 1'b1;
      mc_cnt_d = '0;
    end else begin
      mc_cnt_d = mc_cnt_q + 1'b1;
    end
    mrst_n_d = ctl_q.mclk_rst_wd ? !i_nmi_wd_expired : !fail;
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign wr_ctl = i_wr && (i_addr == IDX_CLOCK_CTRL);

  always_comb begin
    status_view = '0;
    status_view[PLL_LOCK_BIT]         = (pll_st_q == PLL_LOCKED);
    status_view[MISS_FLAG_BIT]        = miss_q;
    status_view[DIV_LSB +: 2]         = div_sel_q;
    status_view[REG_READY_BIT]        = rdy_gate_q;
  end

  always_comb begin
    ext_sel_d  = ext_sel_q;
    div_sel_d  = div_sel_q;
    miss_d     = miss_q;
    rdy_gate_d = rdy_gate_q;
    ctl_d      = ctl_q;
    lock_prd_d = lock_prd_q;
    trim1_d    = trim1_q;
    trim2_d    = trim2_q;
    mult_d     = mult_q;
    gate_a_d   = gate_a_q;
    gate_d_d   = gate_d_q;
    dbg_d      = dbg_q;
    rdata_d    = '0;
    if (i_wr) begin
      case (i_addr)
        IDX_EXT_CLOCK:   ext_sel_d  = i_wdata[EXT_PIN_SEL_BIT];
        IDX_PLL_STATUS: begin
          div_sel_d  = i_wdata[DIV_LSB +: 2];
          rdy_gate_d = i_wdata[REG_READY_BIT];
          if (i_wdata[MISS_FLAG_BIT]) begin
            miss_d = 1'b0;
          end
        end
        IDX_CLOCK_CTRL:  ctl_d      = i_wdata & CLK_CTL_MASK;
        IDX_LOCK_PERIOD: lock_prd_d = i_wdata;
        IDX_OSC1_TRIM:   trim1_d    = i_wdata;
        IDX_OSC2_TRIM:   trim2_d    = i_wdata;
        IDX_PLL_MULT: begin
          if (i_wdata[3:0] <= PLL_MULT_MAX && i_wdata[15:4] == '0) begin
            mult_d = i_wdata[3:0];
          end
        end
        IDX_GATE_A:      gate_a_d   = i_wdata & GATE_A_MASK;
        IDX_GATE_D:      gate_d_d   = i_wdata & GATE_D_MASK;
        IDX_DEBUG_PORT:  dbg_d      = {15'h0000, i_wdata[0]};
        default: ;
      endcase
    end
    // hardware failover beats a software write of the same cycle
    if (fail && osc_sel_cur != SRC_INT1) begin
      ctl_d.osc_src = SRC_INT1;
    end
    if (fail) begin
      miss_d = (osc_sel_cur != SRC_INT2);
    end
    if (i_rd) begin
      case (i_addr)
        IDX_EXT_CLOCK:   rdata_d = {9'h000, ext_sel_q, 6'h00};
        IDX_PLL_STATUS:  rdata_d = status_view;
        IDX_CLOCK_CTRL:  rdata_d = ctl_q;
        IDX_LOCK_PERIOD: rdata_d = lock_prd_q;
        IDX_OSC1_TRIM:   rdata_d = trim1_q;
        IDX_OSC2_TRIM:   rdata_d = trim2_q;
        IDX_PLL_MULT:    rdata_d = {12'h000, mult_q};
        IDX_GATE_A:      rdata_d = gate_a_q;
        IDX_GATE_D:      rdata_d = gate_d_q;
        IDX_DEBUG_PORT:  rdata_d = dbg_q;
        default:         rdata_d = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pll lock wait
  // ----------------------------------------------------------------
  always_comb begin
    pll_st_d   = pll_st_q;
    lock_cnt_d = lock_cnt_q;
    case (pll_st_q)
      PLL_IDLE: begin
        pll_st_d   = PLL_WAIT;
        lock_cnt_d = lock_prd_q;
      end
      PLL_WAIT: begin
        if (lock_cnt_q == '0) begin
          pll_st_d = PLL_LOCKED;
        end else begin
          lock_cnt_d = lock_cnt_q - 1'b1;
        end
      end
      PLL_LOCKED: ;
      default: pll_st_d = PLL_IDLE;
    endcase
    if (i_wr && i_addr == IDX_PLL_MULT) begin
      pll_st_d   = PLL_WAIT;
      lock_cnt_d = lock_prd_q;
    end
    pll_en_d = rdy_gate_q ? i_reg_ready : 1'b1;
  end

  // ----------------------------------------------------------------
  // post-divider
  // ----------------------------------------------------------------
  always_comb begin
    osc_prev_d = osc_clk;
    div_cur_d  = div_cur_q;
    div_cnt_d  = div_cnt_q;
    cpu_d      = cpu_q;
    if (!cpu_q && !osc_clk && div_cnt_q == 2'h0) begin
      div_cur_d = div_sel_q;
    end
    case (div_cur_q)
      DIV_BY_1: cpu_d = osc_clk;
      DIV_BY_2: begin
        if (osc_clk && !osc_prev_q) begin
          cpu_d = !cpu_q;
        end
      end
      default: begin
        if (osc_clk && !osc_prev_q) begin
          div_cnt_d = div_cnt_q + 1'b1;
          if (div_cnt_q[0]) begin
            cpu_d = !cpu_q;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_sel_q  <= 1'b0;
      div_sel_q  <= DIV_RESET;
      miss_q     <= 1'b0;
      rdy_gate_q <= 1'b0;
      ctl_q      <= CLK_CTL_RESET;
      lock_prd_q <= LOCK_PERIOD_RESET;
      trim1_q    <= TRIM_RESET;
      trim2_q    <= TRIM_RESET;
      mult_q     <= PLL_MULT_RESET;
      gate_a_q   <= GATE_A_RESET;
      gate_d_q   <= GATE_D_RESET;
      dbg_q      <= DEBUG_RESET;
      rdata_q    <= '0;
      pll_st_q   <= PLL_IDLE;
      lock_cnt_q <= '0;
      pll_en_q   <= 1'b0;
      mc_cnt_q   <= '0;
      mc_prev_q  <= 1'b0;
      mrst_n_q   <= 1'b1;
      div_cur_q  <= DIV_RESET;
      div_cnt_q  <= 2'h0;
      cpu_q      <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      ext_sel_q  <= ext_sel_d;
      div_sel_q  <= div_sel_d;
      miss_q     <= miss_d;
      rdy_gate_q <= rdy_gate_d;
      ctl_q      <= ctl_d;
      lock_prd_q <= lock_prd_d;
      trim1_q    <= trim1_d;
      trim2_q    <= trim2_d;
      mult_q     <= mult_d;
      gate_a_q   <= gate_a_d;
      gate_d_q   <= gate_d_d;
      dbg_q      <= dbg_d;
      rdata_q    <= rdata_d;
      pll_st_q   <= pll_st_d;
      lock_cnt_q <= lock_cnt_d;
      pll_en_q   <= pll_en_d;
      mc_cnt_q   <= mc_cnt_d;
      mc_prev_q  <= mc_prev_d;
      mrst_n_q   <= mrst_n_d;
      div_cur_q  <= div_cur_d;
      div_cnt_q  <= div_cnt_d;
      cpu_q      <= cpu_d;
      osc_prev_q <= osc_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata                 = rdata_q;
  assign o_oscillator_clock      = osc_clk;
  assign o_cpu_clock             = cpu_q;
  assign o_watchdog_clock        = wd_clk;
  assign o_timer2_clock          = t2_clk;
  assign o_ext_clk_pin_select    = ext_sel_q;
  assign o_osc1_trim             = trim1_q;
  assign o_osc2_trim             = trim2_q;
  assign o_pll_mult              = mult_q;
  assign o_pll_enable            = pll_en_q;
  assign o_missing_clock_reset_n = mrst_n_q;
  assign o_periph_gate_a         = gate_a_q;
  assign o_periph_gate_d         = gate_d_q;
  assign o_debug_port_enable     = dbg_q[0];

  // power-off, halt and gpio input reset controls, held in flip-flops for clean outputs
  logic int1_en_q;
  logic int2_en_q;
  logic xtal_en_q;
  logic ext_en_q;
  logic gpio_rst_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int1_en_q <= 1'b1;
      int2_en_q <= 1'b1;
      xtal_en_q <= 1'b1;
      ext_en_q  <= 1'b1;
      gpio_rst_q <= 1'b0;
    end else begin
      int1_en_q <= !ctl_q.int1_off && !(i_halt && !ctl_q.int1_halt_ign);
      int2_en_q <= !ctl_q.int2_off && !(i_halt && !ctl_q.int2_halt_ign);
      xtal_en_q <= !ctl_q.xtal_off;
      ext_en_q  <= !ctl_q.ext_off;
      gpio_rst_q <= !gate_d_d[GATE_GPIO_BIT];
    end
  end

  assign o_int1_enable = int1_en_q;
  assign o_int2_enable = int2_en_q;
  assign o_xtal_enable = xtal_en_q;
  assign o_ext_enable  = ext_en_q;
  assign o_gpio_input_reset = gpio_rst_q;

endmodule
`default_nettype wire

// [csc_osc_model.sv]
// Purpose: clock sources seen by the clock source control block
// Assumes: levels change just after rising edges of i_clk
// Notes:   a powered-off or stopped source sits low
`timescale 1ns/1ps
`default_nettype none
module csc_osc_model
  import csc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire csc_src_t   i_run,
  input  wire logic [3:0] i_stop,
  output csc_src_t        o_src,
  output logic            o_pin_b
);
  logic [9:0] t_q;
  logic [9:0] t_d;
  // wrap at a common multiple of all periods so no short pulse appears
  always_comb begin
    t_d = (t_q == 10'h347) ? 10'h000 : t_q + 10'h001;
    o_src.int1 = i_run.int1 & ~i_stop[0] & ((t_q % 10'h00a) >= 10'h005);
    o_src.int2 = i_run.int2 & ~i_stop[1] & (((t_q + 10'h003) % 10'h00a) >= 10'h005);
    o_src.xtal = i_run.xtal & ~i_stop[2] & ((t_q % 10'h006) >= 10'h003);
    o_src.ext  = i_run.ext & ~i_stop[3] & ((t_q % 10'h008) >= 10'h004);
    o_pin_b    = i_run.ext & ~i_stop[3] & ((t_q % 10'h00e) >= 10'h007);
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) t_q <= 10'h000;
    else t_q <= t_d;
  end
endmodule
`default_nettype wire

// [csc_checker_assertions.sv]
// Purpose: port assertions of the clock source control block
// Assumes: every source holds a level for three cycles or more
// Notes:   sees the top-level ports only
`timescale 1ns/1ps
`default_nettype none
module csc_checker
  import csc_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_int1_osc,
  input wire logic        i_nmi_wd_expired,
  input wire logic        o_oscillator_clock,
  input wire logic        o_cpu_clock,
  input wire logic        o_timer2_clock,
  input wire logic [3:0]  o_pll_mult,
  input wire logic        o_missing_clock_reset_n,
  input wire logic [15:0] o_periph_gate_d,
  input wire logic        o_gpio_input_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [5:0] age_q;
  logic [5:0] age_d;
  // cycles since reset release, saturating
  always_comb age_d = (age_q == 6'h3f) ? age_q : age_q + 6'h01;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) age_q <= 6'h00;
    else age_q <= age_d;
  end
  sequence high_run(s);
    s [*3];
  endsequence
  sequence slow_run(s);
    s [*8];
  endsequence
  reset_src_a : assert property (age_q >= 6'h02 && age_q < 6'h28 |-> o_oscillator_clock == $past(i_int1_osc))
    else $error("oscillator clock not from first source");
  mult_range_a : assert property (o_pll_mult <= PLL_MULT_MAX)
    else $error("multiplier above limit");
  gpio_reset_a : assert property (o_gpio_input_reset == !o_periph_gate_d[GATE_GPIO_BIT])
    else $error("input reset does not follow gate");
  osc_pulse_a : assert property ($rose(o_oscillator_clock) |-> high_run(o_oscillator_clock))
    else $error("short oscillator clock pulse");
  cpu_pulse_a : assert property ($rose(o_cpu_clock) |-> high_run(o_cpu_clock))
    else $error("short cpu clock pulse");
  cpu_slow_a : assert property ($rose(o_cpu_clock) && age_q < 6'h1e |-> slow_run(o_cpu_clock))
    else $error("cpu clock not divided after reset");
  tmr2_gate_a : assert property (!o_periph_gate_d[GATE_TMR2_BIT] ##1 !o_periph_gate_d[GATE_TMR2_BIT] |-> !o_timer2_clock)
    else $error("timer clock runs while gated");
  miss_pulse_a : assert property ($fell(o_missing_clock_reset_n) && !$past(i_nmi_wd_expired) |=> o_missing_clock_reset_n)
    else $error("detector reset longer than one cycle");
endmodule
`default_nettype wire

// [csc_clock_source_control_bench.sv]
// Purpose: self-checking bench of the clock source control block
// Assumes: lock period shortened to four cycles
// Notes:   sources come from csc_osc_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module csc_clock_source_control_bench;
  import csc_pkg::*;
  logic              i_clk            = 1'b0;
  logic              i_nrst           = 1'b0;
  logic [ADDR_W-1:0] i_addr           = 4'h0;
  logic [DATA_W-1:0] i_wdata          = 16'h0000;
  logic              i_wr             = 1'b0;
  logic              i_rd             = 1'b0;
  logic              i_halt           = 1'b0;
  logic              i_reg_ready      = 1'b0;
  logic              i_nmi_wd_expired = 1'b0;
  logic [3:0]        stop             = 4'h0;
  csc_src_t          src;
  csc_src_t          run;
  logic              pin_b, osc_clk, cpu_clk, wd_clk, t2_clk, pin_sel, pll_en, mrst_n, gpio_rst, dbg, h;
  logic [3:0]        mult;
  logic [15:0]       rdata, trim1, trim2, gate_a, gate_d;
  int                bad_count        = 0;
  int                check_count      = 0;
  int                p;
  logic [3:0]  ridx [11] = '{IDX_EXT_CLOCK, IDX_PLL_STATUS, IDX_CLOCK_CTRL, IDX_LOCK_PERIOD, IDX_OSC1_TRIM,
                            IDX_OSC2_TRIM, IDX_PLL_MULT, IDX_GATE_A, IDX_GATE_D, IDX_DEBUG_PORT, 4'hf};
  logic [15:0] rmsk [11] = '{0: 16'h0040, 1: 16'h0189, default: 16'hffff};
  logic [15:0] rexp [11] = '{16'h0000, 16'h0000, CLK_CTL_RESET, LOCK_PERIOD_RESET, TRIM_RESET, TRIM_RESET,
                            PLL_MULT_RESET, GATE_A_RESET, GATE_D_RESET, DEBUG_RESET, 16'h0000};
  logic [1:0]  dcode [3] = '{DIV_BY_2, DIV_BY_1, DIV_BY_4};
  int          dmul [3]  = '{2, 1, 4};

  csc_clock_source_control uut (
    .i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(rdata),
    .i_int1_osc(src.int1), .i_int2_osc(src.int2), .i_xtal_osc(src.xtal), .i_ext_pin_a(src.ext),
    .i_ext_pin_b(pin_b), .i_halt, .i_reg_ready, .i_nmi_wd_expired,
    .o_oscillator_clock(osc_clk), .o_cpu_clock(cpu_clk), .o_watchdog_clock(wd_clk), .o_timer2_clock(t2_clk),
    .o_ext_clk_pin_select(pin_sel), .o_int1_enable(run.int1), .o_int2_enable(run.int2),
    .o_xtal_enable(run.xtal), .o_ext_enable(run.ext), .o_osc1_trim(trim1), .o_osc2_trim(trim2),
    .o_pll_mult(mult), .o_pll_enable(pll_en), .o_missing_clock_reset_n(mrst_n),
    .o_periph_gate_a(gate_a), .o_periph_gate_d(gate_d), .o_gpio_input_reset(gpio_rst),
    .o_debug_port_enable(dbg)
  );
  csc_osc_model sources (.i_clk, .i_nrst, .i_run(run), .i_stop(stop), .o_src(src), .o_pin_b(pin_b));

  always #5 i_clk = ~i_clk;

  task automatic complete_run;
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset;
    i_nrst <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(rdata & m, e)
    @(posedge i_clk);
  endtask
  // was the watchdog (w=1) or timer clock (w=0) ever high over 40 cycles
  task automatic seen(input logic w, output logic s);
    s = 1'b0;
    repeat (40) begin
      @(negedge i_clk);
      s = s | (w ? wd_clk : t2_clk);
    end
    @(posedge i_clk);
  endtask
  task automatic gap(output int g);
    int n, r0, r1;
    logic last;
    n = 0;
    r0 = -1;
    r1 = -1;
    last = 1'b1;
    while (r1 < 0 && n < 200) begin
      @(negedge i_clk);
      n++;
      if (cpu_clk && !last) begin
        if (r0 < 0) r0 = n;
        else r1 = n;
      end
      last = cpu_clk;
    end
    g = r1 - r0;
    @(posedge i_clk);
  endtask
  task automatic fail_src(input logic [15:0] ctl, input logic [3:0] st, input logic [15:0] flag);
    int n;
    wr(IDX_CLOCK_CTRL, ctl);
    repeat (40) @(posedge i_clk);
    // stop it while low so no pulse is cut
    do @(negedge i_clk); while ((src & st) != 4'h0);
    @(posedge i_clk);
    stop <= st;
    n = 0;
    while (mrst_n !== 1'b0 && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    stop <= 4'h0;
    `CHK(n < 300, 1'b1)
    rc(IDX_PLL_STATUS, 16'h0008, flag);
    rc(IDX_CLOCK_CTRL, 16'h0003, {14'h0000, SRC_INT1});
  endtask

  initial begin
    do_reset();
    for (int k = 0; k < 11; k++) rc(ridx[k], rmsk[k], rexp[k]);
    `CHK(dbg, 1'b1)
    wr(IDX_GATE_A, 16'hffff);
    rc(IDX_GATE_A, 16'hffff, GATE_A_MASK);
    `CHK(gate_a, GATE_A_MASK)
    wr(IDX_GATE_D, 16'hdbff);
    rc(IDX_GATE_D, 16'hffff, 16'h4307);
    `CHK(gate_d, 16'h4307)
    `CHK(gpio_rst, 1'b1)
    seen(1'b0, h);
    `CHK(h, 1'b0)
    wr(IDX_GATE_D, GATE_D_RESET);
    wr(IDX_DEBUG_PORT, 16'h0000);
    `CHK(dbg, 1'b0)
    wr(IDX_OSC1_TRIM, 16'h1234);
    wr(IDX_OSC2_TRIM, 16'h00ab);
    `CHK({trim1, trim2}, 32'h123400ab)
    wr(IDX_LOCK_PERIOD, 16'h0004);
    wr(IDX_PLL_MULT, {12'h000, PLL_MULT_MAX});
    rc(IDX_PLL_STATUS, 16'h0001, 16'h0000);
    repeat (8) @(posedge i_clk);
    rc(IDX_PLL_STATUS, 16'h0001, 16'h0001);
    wr(IDX_PLL_MULT, 16'h000d);
    `CHK(mult, PLL_MULT_MAX)
    wr(IDX_PLL_STATUS, 16'h8000);
    repeat (3) @(posedge i_clk);
    `CHK(pll_en, 1'b0)
    i_reg_ready <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK(pll_en, 1'b1)
    for (int k = 0; k < 3; k++) begin
      wr(IDX_PLL_STATUS, {7'h00, dcode[k], 7'h00});
      rc(IDX_PLL_STATUS, 16'h0180, {7'h00, dcode[k], 7'h00});
      repeat (60) @(posedge i_clk);
      gap(p);
      `CHK(p, dmul[k] * 2 * int'(INT_OSC_HALF_CYC))
    end
    wr(IDX_EXT_CLOCK, 16'h0040);
    `CHK(pin_sel, 1'b1)
    wr(IDX_CLOCK_CTRL, 16'h003f);
    repeat (20) @(posedge i_clk);
    wr(IDX_CLOCK_CTRL, 16'hcdff);
    rc(IDX_CLOCK_CTRL, 16'hffff, 16'h0dff);
    repeat (40) @(posedge i_clk);
    `CHK(run, 4'h8)
    @(negedge i_clk);
    h = pin_b;
    repeat (30) begin
      @(negedge i_clk);
      `CHK(osc_clk, h)
      h = pin_b;
    end
    @(posedge i_clk);
    i_halt <= 1'b1;
    seen(1'b1, h);
    `CHK(h, 1'b1)
    wr(IDX_CLOCK_CTRL, 16'h09ff);
    seen(1'b1, h);
    `CHK(h, 1'b0)
    i_halt <= 1'b0;
    do_reset();
    repeat (50) @(posedge i_clk);
    rc(IDX_CLOCK_CTRL, 16'hffff, CLK_CTL_RESET);
    fail_src(16'h1001, 4'h2, 16'h0000);
    fail_src(16'h1002, 4'h4, 16'h0008);
    wr(IDX_PLL_STATUS, 16'h0008);
    rc(IDX_PLL_STATUS, 16'h0008, 16'h0000);
    wr(IDX_CLOCK_CTRL, 16'h2000);
    i_nmi_wd_expired <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK(mrst_n, 1'b0)
    i_nmi_wd_expired <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK(mrst_n, 1'b1)
    complete_run();
  end

  // tests take some 1000 cycles; allow twenty times
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule

bind csc_clock_source_control csc_checker chk (.i_clk, .i_nrst, .i_int1_osc, .i_nmi_wd_expired, .o_oscillator_clock,
  .o_cpu_clock, .o_timer2_clock, .o_pll_mult, .o_missing_clock_reset_n, .o_periph_gate_d, .o_gpio_input_reset);
`default_nettype wire
